// ### hdl/rsc_pkg.sv
// shared constants and carrier types of the reset source controller
package rsc_pkg;

   // register decode
   localparam logic [7:0] RSC_REG_ADDR = 8'hef;

   // bit positions, shared by flags, enables and source requests
   localparam int unsigned BIT_PIN = 0;
   localparam int unsigned BIT_MON = 1;
   localparam int unsigned BIT_MCD = 2;
   localparam int unsigned BIT_WDT = 3;
   localparam int unsigned BIT_SW = 4;
   localparam int unsigned BIT_CMP = 5;
   localparam int unsigned BIT_FLASH = 6;
   localparam int unsigned BIT_RTC = 7;

   // values after power-on
   localparam logic [7:0] FLAGS_POR = 8'h02;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [15:0] RESET_VECTOR = 16'h0000;

   // timing, figures in microseconds, counts derived from the clock rate
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned MCD_TIMEOUT_US = 100;
   localparam int unsigned MCD_MIN_US = 50;
   localparam int unsigned MCD_MAX_US = 650;
   localparam int unsigned RELEASE_MAX_US = 180;
   localparam int unsigned MCD_TIMEOUT_CYC = MCD_TIMEOUT_US * CLK_MHZ;
   localparam int unsigned RELEASE_CYC = RELEASE_MAX_US * CLK_MHZ;
   localparam int unsigned WDT_DIV = 12;
   localparam logic [3:0] WDT_DIV_LAST = 4'(WDT_DIV - 1);

   // pin history kept after self drive, covers synchroniser latency
   localparam int unsigned DRV_HIST = 4;

   // synchroniser lanes and their idle values
   localparam int unsigned SYNC_W = 6;
   localparam logic [SYNC_W-1:0] SYNC_INIT = 6'h05;

   // sequencer states
   typedef enum logic [2:0]
   {
      ST_RUN = 3'b001,
      ST_HOLD = 3'b010,
      ST_WAIT = 3'b100
   } rsc_state_t;

   // special function register access, one cycle per access
   typedef struct packed
   {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic rmw;
      logic [7:0] wdata;
   } rsc_sfr_req_t;

   // flash access checks from the memory controller
   typedef struct packed
   {
      logic storeWrite;
      logic codeRead;
      logic branch;
      logic aboveLock;
      logic secBlocked;
      logic monitorOn;
   } rsc_flash_req_t;

endpackage

// ### hdl/rsc_reset_ctrl.sv
// reset source collection, cause register and release sequencing
`timescale 1ns/100ps
//
// Contract
// - pin low resets device; pin flag set on exit
// - enabled lost clock detector resets on stuck system clock
// - timeout counts from last system clock rising edge, 50..650 us
// - bit 2 reads detector cause; writing it enables the detector
// - only power sources drive the pin low
// - bit 5 write enables comparator reset, active when noninv below inv
// - bit 5 reads 1 only after comparator reset
// - after any reset watchdog enabled, clocked at system clock over 12; the divider here counts ref_clk over 12
// - watchdog expiry resets; bit 3 reads its cause
// - flash access errors reset the device
// - bit 6 reads flash error cause, read only
// - rtc oscillator fail or alarm requests reset
// - bit 7 enables rtc reset source and reads its cause
// - writing 1 to bit 4 forces reset; bit 4 reads its cause
// - read-modify-write reads enables for bits 7,5,4,2,1; bit 4 reads 0 here
// - bit 1 set on power reset; writing enables supply monitor source
// - code starts at 0x0000 within 180 us of last release
// - every non-power reset clears the power flag
module rsc_reset_ctrl
   import rsc_pkg::*;
#(
   parameter int unsigned MCD_CYC = MCD_TIMEOUT_CYC,
   parameter int unsigned REL_CYC = RELEASE_CYC
)
(
   // clock and power-on reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // special function register port
   input wire rsc_sfr_req_t sfrReq,
   output logic [7:0] sfrRdata,
   // external reset pin, three signals
   input wire logic extResetPinIn,
   output logic extResetPinOut,
   output logic extResetPinOe_n,
   // reset requests
   input wire logic sysClkIn,
   input wire logic cmpNoninvAbove,
   input wire logic rtcOscFail,
   input wire logic rtcAlarm,
   input wire logic monBelow,
   input wire logic wdtExpire,
   input wire rsc_flash_req_t flashReq,
   // towards core and counter array
   output logic coreReset,
   output logic codeStart,
   output logic [15:0] resetVector,
   output logic wdtDefaultLoad,
   output logic wdtTick
);

   localparam logic [15:0] MCD_LAST = 16'(MCD_CYC - 1);
   localparam logic [15:0] REL_LAST = 16'(REL_CYC - 1);

   // register address decode, used by read and write
   function automatic logic isReg(input logic [7:0] a);
      isReg = (a == RSC_REG_ADDR);
   endfunction

   rsc_state_t state_q, state_d;
   logic [7:0] flags_q, flags_d;
   logic [7:0] cause_q, cause_d;
   logic [15:0] relCnt_q, relCnt_d;
   logic [15:0] mcdCnt_q, mcdCnt_d;
   logic enMcd_q, enMcd_d;
   logic enCmp_q, enCmp_d;
   logic enRtc_q, enRtc_d;
   logic enMon_q, enMon_d;
   logic swReq_q, swReq_d;
   logic pinDrive_q, pinDrive_d;
   logic [DRV_HIST-1:0] drvHist_q, drvHist_d;
   logic clkPrev_q, clkPrev_d;
   logic [3:0] wdtDiv_q, wdtDiv_d;
   logic wdtTick_q, wdtTick_d;
   logic wdtLoad_q, wdtLoad_d;
   logic start_q, start_d;
   logic coreRst_q, coreRst_d;
   logic [7:0] rdata_q, rdata_d;
   logic [SYNC_W-1:0] syncIn, syncOut;
   logic pinSync, clkSync, cmpSync, oscSync, alarmSync, monSync;
   logic flashErr, regWrite;
   logic [7:0] src;

   // asynchronous inputs pass four flops before use
   assign syncIn = {monBelow, rtcAlarm, rtcOscFail, cmpNoninvAbove,
                    sysClkIn, extResetPinIn};

   rsc_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync
   (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .din(syncIn),
      .dout(syncOut)
   );

   assign pinSync = syncOut[0];
   assign clkSync = syncOut[1];
   assign cmpSync = syncOut[2];
   assign oscSync = syncOut[3];
   assign alarmSync = syncOut[4];
   assign monSync = syncOut[5];

   // flash access faults, same clock as this block
   assign flashErr = (flashReq.storeWrite & flashReq.aboveLock)
                   | (flashReq.codeRead & flashReq.aboveLock)
                   | (flashReq.branch & flashReq.aboveLock)
                   | flashReq.secBlocked
                   | (flashReq.storeWrite & ~flashReq.monitorOn);

   // request vector, bit positions match the cause register
   always_comb
   begin
      src = 8'h00;
      // our own drive reads back low; ignore pin until it settles
      src[BIT_PIN] = ~pinSync & ~pinDrive_q & ~(|drvHist_q);
      src[BIT_MON] = enMon_q & monSync;
      src[BIT_MCD] = enMcd_q & (state_q == ST_RUN)
                   & (mcdCnt_q == MCD_LAST);
      src[BIT_WDT] = wdtExpire;
      src[BIT_SW] = swReq_q;
      src[BIT_CMP] = enCmp_q & ~cmpSync;
      src[BIT_FLASH] = flashErr;
      src[BIT_RTC] = enRtc_q & (oscSync | alarmSync);
   end

   assign regWrite = sfrReq.wr & isReg(sfrReq.addr) & (state_q == ST_RUN);

   // sequencer: hold while any source stands, then count the release
   always_comb
   begin
      state_d = state_q;
      cause_d = cause_q;
      flags_d = flags_q;
      relCnt_d = relCnt_q;
      pinDrive_d = pinDrive_q;
      wdtLoad_d = 1'b0;
      start_d = 1'b0;
      enMcd_d = enMcd_q;
      enCmp_d = enCmp_q;
      enRtc_d = enRtc_q;
      enMon_d = enMon_q;
      swReq_d = 1'b0;
      if (regWrite)
      begin
         enRtc_d = sfrReq.wdata[BIT_RTC];
         enCmp_d = sfrReq.wdata[BIT_CMP];
         enMcd_d = sfrReq.wdata[BIT_MCD];
         enMon_d = sfrReq.wdata[BIT_MON];
         swReq_d = sfrReq.wdata[BIT_SW];
      end
      case (state_q)
         ST_RUN:
         begin
            if (|src)
            begin
               state_d = ST_HOLD;
               cause_d = src;
               pinDrive_d = src[BIT_MON];
            end
         end
         ST_HOLD:
         begin
            cause_d = cause_q | src;
            if (src[BIT_MON])
            begin
               pinDrive_d = 1'b1;
            end
            if (!(|src))
            begin
               state_d = ST_WAIT;
               relCnt_d = 16'h0000;
            end
         end
         ST_WAIT:
         begin
            if (|src)
            begin
               state_d = ST_HOLD;
               cause_d = cause_q | src;
               if (src[BIT_MON])
               begin
                  pinDrive_d = 1'b1;
               end
            end
            else if (relCnt_q == REL_LAST)
            begin
               // flags only change here, so they name the last cause
               state_d = ST_RUN;
               flags_d = cause_q;
               pinDrive_d = 1'b0;
               wdtLoad_d = 1'b1;
               start_d = 1'b1;
               // plain source enables return off, monitor enable kept
               enMcd_d = 1'b0;
               enCmp_d = 1'b0;
               enRtc_d = 1'b0;
               if (cause_q[BIT_MON])
               begin
                  enMon_d = 1'b1;
               end
            end
            else
            begin
               relCnt_d = relCnt_q + 16'h0001;
            end
         end
         default:
         begin
            state_d = ST_HOLD;
         end
      endcase
   end

   // lost clock timer, restarted by each rising system clock edge
   always_comb
   begin
      clkPrev_d = clkSync;
      mcdCnt_d = mcdCnt_q;
      if (!enMcd_q || state_q != ST_RUN || (clkSync && !clkPrev_q))
      begin
         mcdCnt_d = 16'h0000;
      end
      else if (mcdCnt_q != MCD_LAST)
      begin
         mcdCnt_d = mcdCnt_q + 16'h0001;
      end
   end

   // watchdog clock divider, restarts at every release
   always_comb
   begin
      wdtDiv_d = wdtDiv_q;
      wdtTick_d = 1'b0;
      if (state_q != ST_RUN)
      begin
         wdtDiv_d = 4'h0;
      end
      else if (wdtDiv_q == WDT_DIV_LAST)
      begin
         wdtDiv_d = 4'h0;
         wdtTick_d = 1'b1;
      end
      else
      begin
         wdtDiv_d = wdtDiv_q + 4'h1;
      end
   end

   // read path; modify cycles see enables, plain reads see flags
   always_comb
   begin
      rdata_d = rdata_q;
      drvHist_d = {drvHist_q[DRV_HIST-2:0], pinDrive_q};
      coreRst_d = (state_d != ST_RUN);
      if (sfrReq.rd)
      begin
         rdata_d = 8'h00;
         if (isReg(sfrReq.addr))
         begin
            rdata_d = flags_q;
            if (sfrReq.rmw)
            begin
               rdata_d[BIT_RTC] = enRtc_q;
               rdata_d[BIT_CMP] = enCmp_q;
               rdata_d[BIT_SW] = 1'b0;
               rdata_d[BIT_MCD] = enMcd_q;
               rdata_d[BIT_MON] = enMon_q;
            end
         end
      end
   end

   // power-on acts as a supply reset: wait, pin driven low
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_q <= ST_WAIT;
         cause_q <= FLAGS_POR;
         flags_q <= FLAGS_POR;
         relCnt_q <= 16'h0000;
         mcdCnt_q <= 16'h0000;
         enMcd_q <= 1'b0;
         enCmp_q <= 1'b0;
         enRtc_q <= 1'b0;
         enMon_q <= 1'b1;
         swReq_q <= 1'b0;
         pinDrive_q <= 1'b1;
         drvHist_q <= '1;
         clkPrev_q <= 1'b0;
         wdtDiv_q <= 4'h0;
         wdtTick_q <= 1'b0;
         wdtLoad_q <= 1'b0;
         start_q <= 1'b0;
         coreRst_q <= 1'b1;
         rdata_q <= RDATA_RST;
      end
      else
      begin
         state_q <= state_d;
         cause_q <= cause_d;
         flags_q <= flags_d;
         relCnt_q <= relCnt_d;
         mcdCnt_q <= mcdCnt_d;
         enMcd_q <= enMcd_d;
         enCmp_q <= enCmp_d;
         enRtc_q <= enRtc_d;
         enMon_q <= enMon_d;
         swReq_q <= swReq_d;
         pinDrive_q <= pinDrive_d;
         drvHist_q <= drvHist_d;
         clkPrev_q <= clkPrev_d;
         wdtDiv_q <= wdtDiv_d;
         wdtTick_q <= wdtTick_d;
         wdtLoad_q <= wdtLoad_d;
         start_q <= start_d;
         coreRst_q <= coreRst_d;
         rdata_q <= rdata_d;
      end
   end

   // outputs
   assign sfrRdata = rdata_q;
   assign extResetPinOut = 1'b0;
   assign extResetPinOe_n = ~pinDrive_q;
   assign coreReset = coreRst_q;
   assign codeStart = start_q;
   assign resetVector = RESET_VECTOR;
   assign wdtDefaultLoad = wdtLoad_q;
   assign wdtTick = wdtTick_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence seqSwWrite;
      regWrite && sfrReq.wdata[BIT_SW];
   endsequence

   sequence seqRelease;
      state_q == ST_WAIT && !(|src) && relCnt_q == REL_LAST;
   endsequence

   chk_pin_enter: assert property
      (state_q == ST_RUN && src[BIT_PIN] |=> state_q == ST_HOLD && coreReset)
      else $error("pin request did not enter reset");

   chk_mcd_timeout: assert property
      (src[BIT_MCD] |=> state_q == ST_HOLD ##0 cause_q[BIT_MCD])
      else $error("clock timeout did not reset");

   chk_sw_force: assert property
      (seqSwWrite |-> ##2 state_q == ST_HOLD && cause_q[BIT_SW])
      else $error("software force did not reset");

   chk_flag_latch: assert property
      (seqRelease |=> flags_q == $past(cause_q) && codeStart && !coreReset)
      else $error("flags not taken from cause at release");

   chk_por_clear: assert property
      (seqRelease ##0 !cause_q[BIT_MON] |=> !flags_q[BIT_MON])
      else $error("power flag kept after other reset");

   chk_pin_undriven: assert property
      (state_q == ST_HOLD && !cause_q[BIT_MON] |-> extResetPinOe_n)
      else $error("pin driven by non-power reset");

   chk_rmw_enable: assert property
      (sfrReq.rd && sfrReq.rmw && isReg(sfrReq.addr)
       |=> sfrRdata[BIT_CMP] == $past(enCmp_q)
           && sfrRdata[BIT_RTC] == $past(enRtc_q))
      else $error("modify read did not return enables");

   chk_wdt_period: assert property
      (wdtTick |=> !wdtTick [*8] ##1 !wdtTick ##1 !wdtTick ##1 !wdtTick)
      else $error("watchdog tick spacing wrong");

   chk_release_bound: assert property
      (state_q == ST_WAIT && !(|src) && relCnt_q != REL_LAST
       |=> relCnt_q == $past(relCnt_q) + 16'h0001 && relCnt_q <= REL_LAST)
      else $error("release count stalled or overran");

   chk_cmp_reset: assert property
      (state_q == ST_RUN && enCmp_q && !cmpSync |=> cause_q[BIT_CMP])
      else $error("comparator request ignored");

endmodule

// ### hdl/rsc_sync.sv
// three-stage input synchroniser with agreement check
`timescale 1ns/100ps
module rsc_sync
   import rsc_pkg::*;
#(
   parameter int unsigned W = SYNC_W,
   parameter logic [W-1:0] INIT = SYNC_INIT
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // asynchronous lanes in, settled lanes out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] s1_q, s2_q, s3_q, out_q;
   logic [W-1:0] out_d;

   // a lane changes only once stages two and three agree
   always_comb
   begin
      for (int i = 0; i < W; i++)
      begin
         out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
   end

   // stage one feeds stage two only
   always_ff @(posedge ref_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
         out_q <= INIT;
      end
      else
      begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign dout = out_q;

endmodule

// ### tb/reset_source_controller_tb.sv
// self-checking bench of the reset source controller
`timescale 1ns/100ps
module reset_source_controller_tb;
   import rsc_pkg::*;
   localparam int unsigned MCD_SIM = 50;
   localparam int unsigned REL_SIM = 20;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   rsc_sfr_req_t sfrReq = '0;
   rsc_flash_req_t flashReq = 6'h01;
   logic [7:0] sfrRdata;
   logic pinLevel, pinOut, pinOe_n, system_clock, coreReset, codeStart;
   logic cmpAbove = 1'b1, rtcOsc = 1'b0, rtcAlm = 1'b0, monBelow = 1'b0;
   logic wdtExp = 1'b0, pressPin = 1'b0, stallClk = 1'b0, rdLag = 1'b0;
   logic wdtLoad, wdtTick;
   logic [15:0] resetVector;
   logic [7:0] expQ[$];
   logic [7:0] en [0:9] = '{8'h22, 8'h82, 8'h82, 8'h02, 8'h02,
      8'h02, 8'h02, 8'h02, 8'h02, 8'h02};
   int sel [0:9] = '{0, 1, 2, 4, 3, 5, 5, 5, 5, 5};
   logic [5:0] fp [0:9] = '{6'h01, 6'h01, 6'h01, 6'h01, 6'h01,
      6'h25, 6'h15, 6'h0d, 6'h03, 6'h20};
   logic [7:0] ex [0:9] = '{8'h20, 8'h80, 8'h80, 8'h08, 8'h02,
      8'h40, 8'h40, 8'h40, 8'h40, 8'h40};
   int error_cnt = 0;
   int total_checks = 0;
   int n, gap, i;
   logic [7:0] v;

   rsc_reset_ctrl #(.MCD_CYC(MCD_SIM), .REL_CYC(REL_SIM)) dut_u (
      .ref_clk(ref_clk), .arst_n(arst_n), .sfrReq(sfrReq),
      .sfrRdata(sfrRdata), .extResetPinIn(pinLevel),
      .extResetPinOut(pinOut), .extResetPinOe_n(pinOe_n),
      .sysClkIn(system_clock), .cmpNoninvAbove(cmpAbove), .rtcOscFail(rtcOsc),
      .rtcAlarm(rtcAlm), .monBelow(monBelow), .wdtExpire(wdtExp),
      .flashReq(flashReq), .coreReset(coreReset), .codeStart(codeStart),
      .resetVector(resetVector), .wdtDefaultLoad(wdtLoad),
      .wdtTick(wdtTick));

   rsc_ext_model ext_u (
      .ref_clk(ref_clk), .pressPin(pressPin), .stallClk(stallClk),
      .pinOut(pinOut), .pinOe_n(pinOe_n), .pinLevel(pinLevel),
      .system_clock(system_clock));

   // free-running 100 MHz clock
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask

   task automatic sfr_wr(input logic [7:0] d);
      sfrReq.addr = RSC_REG_ADDR;
      sfrReq.wdata = d;
      sfrReq.wr = 1'b1;
      tick();
      sfrReq.wr = 1'b0;
      // idle edge keeps strobes of back-to-back calls apart
      tick();
   endtask

   // the note goes on the queue before the strobe is raised
   task automatic sfr_rd(input logic [7:0] a, input logic m,
                         input logic [7:0] e);
      expQ.push_back(e);
      sfrReq.addr = a;
      sfrReq.rmw = m;
      sfrReq.rd = 1'b1;
      tick();
      sfrReq.rd = 1'b0;
      sfrReq.rmw = 1'b0;
      tick();
   endtask

   task automatic set_src(input int s, input logic [5:0] f, input logic on);
      cmpAbove = !(on && s == 0);
      rtcOsc = on && s == 1;
      rtcAlm = on && s == 2;
      monBelow = on && s == 3;
      wdtExp = on && s == 4;
      flashReq = (on && s == 5) ? f : 6'h01;
   endtask

   // waits out one reset, then reads back the recorded cause
   task automatic expect_release(input logic [7:0] e, input logic drv,
                                 input int maxN);
      for (n = 0; n < 100 && coreReset !== 1'b1; n++)
         tick();
      chk("reset entered", 1'b1, coreReset);
      chk("pin enable", !drv, pinOe_n);
      chk("pin out", 1'b0, pinOut);
      for (n = 0; n < 3000 && codeStart !== 1'b1; n++)
         tick();
      chk("release time", 1'b1, n <= maxN);
      chk("core released", 1'b0, coreReset);
      chk("vector", 16'h0000, resetVector);
      chk("watchdog load", 1'b1, wdtLoad);
      tick();
      sfr_rd(RSC_REG_ADDR, 1'b0, e);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // each read answer is compared with the oldest note
   always @(posedge ref_clk)
   begin
      if (rdLag)
         chk("read data", expQ.pop_front(), sfrRdata);
      rdLag <= sfrReq.rd;
   end

   // hang guard, well beyond the expected run
   initial
   begin
      #400000;
      error_cnt++;
      end_sim();
   end

   initial
   begin
      v = 8'($urandom(33));
      repeat (8) @(posedge ref_clk);
      #1;
      arst_n = 1'b1;
      expect_release(8'h02, 1'b1, REL_SIM + 10);
      sfr_rd(8'hee, 1'b0, 8'h00);
      sfr_rd(RSC_REG_ADDR, 1'b1, 8'h02);
      for (n = 0; n < 40 && wdtTick !== 1'b1; n++)
         tick();
      tick();
      for (gap = 1; gap < 40 && wdtTick !== 1'b1; gap++)
         tick();
      chk("tick gap", 16'(WDT_DIV), 16'(gap));
      $display("test power-on done");
      sfr_wr(8'h12);
      expect_release(8'h10, 1'b0, REL_SIM + 10);
      sfr_rd(RSC_REG_ADDR, 1'b1, 8'h02);
      $display("test software force done");
      // random enables must come back on a read-modify-write read
      repeat (4)
      begin
         v = (8'($urandom) & 8'ha6) | 8'h02;
         sfr_wr(v);
         sfr_rd(RSC_REG_ADDR, 1'b1, v);
         sfr_rd(RSC_REG_ADDR, 1'b0, 8'h10);
      end
      $display("test enable readback done");
      pressPin = 1'b1;
      tick();
      pressPin = 1'b0;
      expect_release(8'h01, 1'b0, 2100);
      $display("test pin done");
      // comparator input is settled high before its enable is written
      for (i = 0; i < 10; i++)
      begin
         sfr_wr(en[i]);
         set_src(sel[i], fp[i], 1'b1);
         repeat (8) tick();
         set_src(sel[i], fp[i], 1'b0);
         expect_release(ex[i], sel[i] == 3, 60);
      end
      $display("test source table done");
      sfr_wr(8'h06);
      stallClk = 1'b1;
      for (n = 0; n < 100 && coreReset !== 1'b1; n++)
         tick();
      stallClk = 1'b0;
      chk("clock timeout", 1'b1,
          n >= MCD_SIM - 12 && n <= MCD_SIM + 10);
      expect_release(8'h04, 1'b0, 60);
      $display("test lost clock done");
      // enables were cleared at release, so these must be ignored
      for (i = 0; i < 3; i++)
      begin
         set_src(i, 6'h01, 1'b1);
         repeat (8) tick();
         set_src(i, 6'h01, 1'b0);
         chk("disabled source", 1'b0, coreReset);
         tick();
      end
      repeat (3) tick();
      $display("test disabled sources done");
      // a second power-on in mid-run brings back the power flag
      arst_n = 1'b0;
      repeat (2) tick();
      arst_n = 1'b1;
      expect_release(8'h02, 1'b1, REL_SIM + 10);
      sfr_rd(RSC_REG_ADDR, 1'b1, 8'h02);
      $display("test second power-on done");
      end_sim();
   end
endmodule

// ### tb/rsc_ext_model.sv
// far-side model: reset pin circuitry and the observed system clock
`timescale 1ns/100ps
module rsc_ext_model
#(
   parameter int unsigned HOLD_CYC = 2000,
   parameter int unsigned CLK_DIV = 5
)
(
   // clock
   input wire logic ref_clk,
   // commands from the bench
   input wire logic pressPin,
   input wire logic stallClk,
   // pin as the device drives it
   input wire logic pinOut,
   input wire logic pinOe_n,
   // resolved lines
   output logic pinLevel,
   output logic system_clock = 1'b0
);
   int holdCnt = 0;
   int divCnt = 0;

   // pull-up wins unless some party drives the pin low
   assign pinLevel = !pinOe_n ? pinOut : (holdCnt != 0) ? 1'b0 : 1'b1;

   // one press keeps the pin low for the whole minimum time
   always @(posedge ref_clk)
   begin
      if (pressPin && holdCnt == 0)
         holdCnt <= HOLD_CYC;
      else if (holdCnt != 0)
         holdCnt <= holdCnt - 1;
   end

   // slow clock so the sampler sees every edge; frozen on a stall
   always @(posedge ref_clk)
   begin
      if (!stallClk && divCnt == CLK_DIV - 1)
         system_clock <= ~system_clock;
      if (!stallClk)
         divCnt <= (divCnt == CLK_DIV - 1) ? 0 : divCnt + 1;
   end
endmodule
